// File: src/ifsf_map.svh
// register offsets, field positions, reset values and codes of the framer
`ifndef IFSF_MAP_SVH
`define IFSF_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define IFSF_REG_CTRL 8'h00
`define IFSF_REG_BLKCNT 8'h04
`define IFSF_REG_BLKLEN 8'h08
`define IFSF_REG_KFAC 8'h0C
`define IFSF_REG_CMD 8'h10
`define IFSF_REG_CNT_LO 8'h14
`define IFSF_REG_CNT_HI 8'h18
`define IFSF_REG_TIME_LO 8'h1C
`define IFSF_REG_TIME_HI 8'h20
`define IFSF_REG_STAT 8'h24
`define IFSF_REG_MASK 8'h28

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define IFSF_CTRL_EN 0
`define IFSF_CTRL_KVALID 1
`define IFSF_CTRL_FMT_HI 3
`define IFSF_CTRL_FMT_LO 2
`define IFSF_CTRL_USER_HI 9
`define IFSF_CTRL_USER_LO 4
`define IFSF_CMD_RESTART 0
`define IFSF_EV_DONE 0
`define IFSF_EV_OVL 1
`define IFSF_EV_RESTART 2
`define IFSF_EV_DROP 3
`define IFSF_EV_W 4

// ----------------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------------
`define IFSF_CTRL_RST 10'h000
`define IFSF_LEN_RST 16'h0000
`define IFSF_KFAC_RST 32'h0000_0000
`define IFSF_MASK_RST 4'h0
`define IFSF_KFAC_NONE 32'h8000_0000
`define IFSF_HDR_LEN 5'h13
`define IFSF_HDR_FIRST 3'h0
`define IFSF_HDR_LAST 3'h4
`define IFSF_RSVD_ZERO 8'h00

// ----------------------------------------------------------------------
// sample format codes
// ----------------------------------------------------------------------
`define IFSF_FMT_C64_FIX 2'h0
`define IFSF_FMT_C64_FLT 2'h1
`define IFSF_FMT_C32_FIX 2'h2
`define IFSF_FMT_R16_FIX 2'h3

`endif

// File: src/ifsf_pkg.sv
// shared types of the IF stream block framer
package ifsf_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_STAT, ST_BODY} ifsf_state_t;

	typedef struct packed {
		logic [31:0] re;
		logic [31:0] im;
	} ifsf_sample_t;

	typedef struct packed {
		logic [15:0] agc_gain_correction;
		logic [7:0] reserved;
		logic [5:0] user_flags;
		logic blanked;
		logic invalid;
	} ifsf_status_t;

	typedef struct packed {
		logic [15:0] block_count;
		logic [15:0] block_length_words;
		logic [1:0] fmt;
		logic [31:0] antenna_field_correction;
		logic [5:0] user_flags;
		logic [63:0] stream_start_time_ns;
		logic [63:0] sample_count;
	} ifsf_snap_t;
endpackage

// File: src/ifsf_sticky.sv
// write-one-to-clear sticky event flags
`timescale 1ns/100ps
module ifsf_sticky #(
	parameter int W = 4
) (
	input wire logic core_clk_in, // block clock
	input wire logic rst_n_in, // sync reset, active low
	input wire logic [W-1:0] set_in, // event pulses
	input wire logic [W-1:0] clr_in, // ones written by software
	output logic [W-1:0] flag_out // sticky flags
);
	// a set in the clearing cycle survives
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			flag_out <= '0;
		end else begin
			flag_out <= (flag_out & ~clr_in) | set_in;
		end
	end
endmodule // ifsf_sticky

// File: src/ifsf_packer.sv
// packs held samples into 32-bit body words per sample format
`timescale 1ns/100ps
`include "ifsf_map.svh"
module ifsf_packer (
	input wire logic core_clk_in, // block clock
	input wire logic rst_n_in, // sync reset, active low
	input wire logic [1:0] fmt_in, // sample format code
	input wire logic run_in, // body words wanted
	input wire logic flush_in, // block start, drop phase
	input wire logic s_valid_in, // sample offered
	input wire ifsf_pkg::ifsf_sample_t s_in, // sample
	output logic s_ready_out, // sample consumed
	output logic w_valid_out, // word available
	output logic [31:0] w_data_out, // packed word
	input wire logic w_ready_in // word taken
);
	logic phase;
	logic [15:0] low_half;

	always_comb begin
		w_valid_out = 1'b0;
		w_data_out = s_in.re;
		s_ready_out = 1'b0;
		unique case (fmt_in)
		`IFSF_FMT_C64_FIX, `IFSF_FMT_C64_FLT: begin
			// real word first, imaginary second
			w_valid_out = run_in & s_valid_in;
			w_data_out = phase ? s_in.im : s_in.re;
			s_ready_out = run_in & phase & w_ready_in;
		end
		`IFSF_FMT_C32_FIX: begin
			// fractions keep their top 16 bits: same scale, less precision
			w_valid_out = run_in & s_valid_in;
			w_data_out = {s_in.im[31:16], s_in.re[31:16]}; // R18
			s_ready_out = run_in & w_ready_in;
		end
		`IFSF_FMT_R16_FIX: begin
			// first sample parks in the low half, second goes high
			w_valid_out = run_in & s_valid_in & phase;
			w_data_out = {s_in.re[31:16], low_half}; // R18
			s_ready_out = run_in & (phase ? w_ready_in : 1'b1);
		end
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || flush_in) begin
			phase <= 1'b0;
			low_half <= 16'h0000;
		end else if (fmt_in == `IFSF_FMT_C32_FIX) begin
			phase <= 1'b0;
		end else if (s_valid_in
			&& (s_ready_out || (w_valid_out && w_ready_in))) begin
			phase <= ~phase;
			if (!phase) begin
				low_half <= s_in.re[31:16];
			end
		end
	end
endmodule // ifsf_packer

// File: src/ifsf_framer.sv
// extended header tail and datablock builder of the IF sample stream
`timescale 1ns/100ps
`include "ifsf_map.svh"

// Operation
// R1 - start time fixed until restart or resync
// R2 - 64-bit sample count, low word then high
// R3 - count zeroes only on restart or resync
// R4 - count advances by samples actually sent
// R5 - receiver derives sample time from header
// R6 - antenna correction, none gives 0x80000000
// R7 - extended data header is nineteen words
// R8 - header fields frozen at frame start
// R9 - exactly the programmed number of blocks
// R10 - every block opens with a status word
// R11 - status top half carries AGC correction
// R12 - status bits 15 to 8 are zero
// R13 - bit 1 flags externally falsified data
// R14 - bit 0 flags corrupt or misdescribed data
// R15 - body holds block length data words
// R16 - packing follows configured sample format
// R17 - complex64, complex32 and real16 packings
// R18 - fixed formats are signed fractions
// R19 - bits 7 to 2 only as user flags
module ifsf_framer (
	input wire logic core_clk_in, // 50 MHz block clock
	input wire logic rst_n_in, // sync reset, active low
	input wire logic [7:0] reg_addr_in, // register byte address
	input wire logic [31:0] reg_wdata_in, // register write data
	input wire logic reg_wr_in, // register write strobe
	input wire logic reg_rd_in, // register read strobe
	output logic [31:0] reg_rdata_out, // read data, one cycle later
	input wire logic frame_req_in, // pulse: build next frame
	input wire logic [63:0] time_ns_in, // running time in ns
	input wire logic tuner_sync_in, // pulse: tuner resynchronised
	input wire logic [15:0] agc_gain_in, // current AGC correction
	input wire logic blank_in, // external disturbance level
	input wire logic overload_in, // converter or analog overload
	input wire logic sample_valid_in, // sample offered
	input wire ifsf_pkg::ifsf_sample_t sample_in, // I/Q sample
	output logic sample_ready_out, // sample holder free
	output logic word_valid_out, // frame word valid
	output logic [31:0] word_data_out, // frame word
	output logic word_last_out, // last word of frame
	input wire logic word_ready_in, // consumer takes word
	output logic [4:0] hdr_len_out, // data header length in words
	output logic busy_out, // frame in progress
	output logic irq_out // unmasked event pending
);
	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	logic [9:0] ctrl;
	logic [15:0] blk_cnt_reg;
	logic [15:0] blk_len_reg;
	logic [31:0] kfac_reg;
	logic [`IFSF_EV_W-1:0] irq_mask;
	logic [`IFSF_EV_W-1:0] irq_stat;
	logic [`IFSF_EV_W-1:0] ev_set;
	logic [`IFSF_EV_W-1:0] ev_clr;
	logic [63:0] sample_count;
	logic [63:0] start_time;
	logic fresh;
	logic restart;
	logic wr_cmd;

	assign wr_cmd = reg_wr_in && reg_addr_in == `IFSF_REG_CMD;
	assign restart = tuner_sync_in || (wr_cmd && reg_wdata_in[`IFSF_CMD_RESTART]);

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			ctrl <= `IFSF_CTRL_RST;
			blk_cnt_reg <= `IFSF_LEN_RST;
			blk_len_reg <= `IFSF_LEN_RST;
			kfac_reg <= `IFSF_KFAC_RST;
			irq_mask <= `IFSF_MASK_RST;
		end else if (reg_wr_in) begin
			unique case (reg_addr_in)
			`IFSF_REG_CTRL: ctrl <= reg_wdata_in[9:0];
			`IFSF_REG_BLKCNT: blk_cnt_reg <= reg_wdata_in[15:0];
			`IFSF_REG_BLKLEN: blk_len_reg <= reg_wdata_in[15:0];
			`IFSF_REG_KFAC: kfac_reg <= reg_wdata_in;
			`IFSF_REG_MASK: irq_mask <= reg_wdata_in[`IFSF_EV_W-1:0];
			default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 32'h0000_0000;
		end else if (reg_rd_in) begin
			unique case (reg_addr_in)
			`IFSF_REG_CTRL: reg_rdata_out <= {22'h00_0000, ctrl};
			`IFSF_REG_BLKCNT: reg_rdata_out <= {16'h0000, blk_cnt_reg};
			`IFSF_REG_BLKLEN: reg_rdata_out <= {16'h0000, blk_len_reg};
			`IFSF_REG_KFAC: reg_rdata_out <= kfac_reg;
			`IFSF_REG_CNT_LO: reg_rdata_out <= sample_count[31:0];
			`IFSF_REG_CNT_HI: reg_rdata_out <= sample_count[63:32];
			`IFSF_REG_TIME_LO: reg_rdata_out <= start_time[31:0];
			`IFSF_REG_TIME_HI: reg_rdata_out <= start_time[63:32];
			`IFSF_REG_STAT: reg_rdata_out <= {28'h000_0000, irq_stat};
			`IFSF_REG_MASK: reg_rdata_out <= {28'h000_0000, irq_mask};
			default: reg_rdata_out <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata_out <= 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------------
	// sample holder: one entry so the ready output is a flop
	// ------------------------------------------------------------------
	ifsf_pkg::ifsf_sample_t hold;
	logic hold_full;
	logic take;
	logic pk_s_ready;
	logic next_hold_full;

	assign take = hold_full && pk_s_ready;
	assign next_hold_full = (hold_full && !take)
		|| (sample_valid_in && sample_ready_out);

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			hold_full <= 1'b0;
			sample_ready_out <= 1'b0;
			hold <= '0;
		end else begin
			hold_full <= next_hold_full;
			sample_ready_out <= !next_hold_full;
			if (sample_valid_in && sample_ready_out) begin
				hold <= sample_in;
			end
		end
	end

	// ------------------------------------------------------------------
	// stream time base and running sample count
	// ------------------------------------------------------------------
	ifsf_pkg::ifsf_state_t state;
	ifsf_pkg::ifsf_snap_t snap;
	logic accept;

	assign accept = state == ifsf_pkg::ST_IDLE && frame_req_in
		&& ctrl[`IFSF_CTRL_EN];

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			sample_count <= 64'h0000_0000_0000_0000;
		end else if (restart) begin
			sample_count <= {63'h0, take}; // R3
		end else begin
			sample_count <= sample_count + {63'h0, take}; // R4
		end
	end

	// time of sample zero is taken when the restarted stream's first
	// frame is accepted; that frame's first sample is sample zero
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			fresh <= 1'b1;
			start_time <= 64'h0000_0000_0000_0000;
		end else if (restart) begin
			fresh <= 1'b1;
		end else if (accept && fresh) begin
			fresh <= 1'b0;
			start_time <= time_ns_in; // R1
		end
	end

	// ------------------------------------------------------------------
	// per-block status flags gathered since the last status word
	// ------------------------------------------------------------------
	logic blank_acc;
	logic bad_acc;
	logic emit;
	logic stat_emit;
	ifsf_pkg::ifsf_status_t status_word;

	assign stat_emit = emit && state == ifsf_pkg::ST_STAT;

	always_comb begin
		status_word.agc_gain_correction = agc_gain_in; // R11
		status_word.reserved = `IFSF_RSVD_ZERO; // R12
		status_word.user_flags = snap.user_flags; // R19
		status_word.blanked = blank_acc || blank_in; // R13
		status_word.invalid = bad_acc || overload_in; // R14
	end

	// a restart inside a frame leaves its header wrong for the blocks
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			blank_acc <= 1'b0;
			bad_acc <= 1'b0;
		end else begin
			blank_acc <= (blank_acc && !stat_emit) || blank_in;
			bad_acc <= (bad_acc && !stat_emit) || overload_in
				|| (restart && state != ifsf_pkg::ST_IDLE); // R14
		end
	end

	// ------------------------------------------------------------------
	// frame sequencer
	// ------------------------------------------------------------------
	logic [2:0] hdr_idx;
	logic [15:0] blk_idx;
	logic [15:0] word_cnt;
	logic slot;
	logic final_blk;
	logic pk_w_valid;
	logic [31:0] pk_w_data;
	logic [31:0] next_data;
	logic next_last;

	assign slot = !word_valid_out || word_ready_in;
	assign final_blk = blk_idx == snap.block_count - 16'h0001;

	always_comb begin
		emit = 1'b0;
		next_data = pk_w_data;
		next_last = 1'b0;
		unique case (state)
		ifsf_pkg::ST_IDLE: ;
		ifsf_pkg::ST_HDR: begin
			emit = slot;
			next_last = hdr_idx == `IFSF_HDR_LAST
				&& snap.block_count == 16'h0000;
			unique case (hdr_idx)
			3'h0: next_data = snap.stream_start_time_ns[31:0]; // R1
			3'h1: next_data = snap.stream_start_time_ns[63:32];
			3'h2: next_data = snap.sample_count[31:0]; // R2
			3'h3: next_data = snap.sample_count[63:32]; // R2
			default: next_data = snap.antenna_field_correction; // R6
			endcase
		end
		ifsf_pkg::ST_STAT: begin
			emit = slot;
			next_data = status_word; // R10
			next_last = final_blk && snap.block_length_words == 16'h0000;
		end
		ifsf_pkg::ST_BODY: begin
			emit = slot && pk_w_valid; // R15
			next_last = final_blk
				&& word_cnt == snap.block_length_words - 16'h0001;
		end
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			state <= ifsf_pkg::ST_IDLE;
			hdr_idx <= `IFSF_HDR_FIRST;
			blk_idx <= 16'h0000;
			word_cnt <= 16'h0000;
			snap <= '0;
		end else begin
			unique case (state)
			ifsf_pkg::ST_IDLE: if (accept) begin
				snap.block_count <= blk_cnt_reg; // R8
				snap.block_length_words <= blk_len_reg;
				snap.fmt <= ctrl[`IFSF_CTRL_FMT_HI:`IFSF_CTRL_FMT_LO];
				snap.antenna_field_correction <= ctrl[`IFSF_CTRL_KVALID]
					? kfac_reg : `IFSF_KFAC_NONE; // R6
				snap.user_flags <= ctrl[`IFSF_CTRL_USER_HI:`IFSF_CTRL_USER_LO];
				snap.stream_start_time_ns <= fresh ? time_ns_in : start_time;
				snap.sample_count <= sample_count; // R2
				hdr_idx <= `IFSF_HDR_FIRST;
				blk_idx <= 16'h0000;
				state <= ifsf_pkg::ST_HDR;
			end
			ifsf_pkg::ST_HDR: if (emit) begin
				hdr_idx <= hdr_idx + 3'h1;
				if (hdr_idx == `IFSF_HDR_LAST) begin
					state <= snap.block_count == 16'h0000
						? ifsf_pkg::ST_IDLE : ifsf_pkg::ST_STAT; // R9
				end
			end
			ifsf_pkg::ST_STAT: if (emit) begin
				word_cnt <= 16'h0000;
				if (snap.block_length_words != 16'h0000) begin
					state <= ifsf_pkg::ST_BODY;
				end else if (final_blk) begin
					state <= ifsf_pkg::ST_IDLE;
				end else begin
					blk_idx <= blk_idx + 16'h0001;
				end
			end
			ifsf_pkg::ST_BODY: if (emit) begin
				word_cnt <= word_cnt + 16'h0001;
				if (word_cnt == snap.block_length_words - 16'h0001) begin
					word_cnt <= 16'h0000;
					if (final_blk) begin
						state <= ifsf_pkg::ST_IDLE; // R9
					end else begin
						blk_idx <= blk_idx + 16'h0001;
						state <= ifsf_pkg::ST_STAT; // R10
					end
				end
			end
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			word_valid_out <= 1'b0;
			word_data_out <= 32'h0000_0000;
			word_last_out <= 1'b0;
			busy_out <= 1'b0;
			hdr_len_out <= `IFSF_HDR_LEN;
		end else begin
			hdr_len_out <= `IFSF_HDR_LEN; // R7
			busy_out <= accept || (state != ifsf_pkg::ST_IDLE
				&& !(emit && next_last));
			if (emit) begin
				word_valid_out <= 1'b1;
				word_data_out <= next_data;
				word_last_out <= next_last;
			end else if (word_ready_in) begin
				word_valid_out <= 1'b0;
				word_last_out <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// body packing
	// ------------------------------------------------------------------
	ifsf_packer u_packer (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.fmt_in(snap.fmt), // R16
		.run_in(state == ifsf_pkg::ST_BODY && slot),
		.flush_in(state == ifsf_pkg::ST_STAT),
		.s_valid_in(hold_full),
		.s_in(hold),
		.s_ready_out(pk_s_ready),
		.w_valid_out(pk_w_valid),
		.w_data_out(pk_w_data),
		.w_ready_in(slot)
	); // R17

	// ------------------------------------------------------------------
	// events and interrupt
	// ------------------------------------------------------------------
	always_comb begin
		ev_set = '0;
		ev_set[`IFSF_EV_DONE] = emit && next_last;
		ev_set[`IFSF_EV_OVL] = overload_in;
		ev_set[`IFSF_EV_RESTART] = restart;
		ev_set[`IFSF_EV_DROP] = frame_req_in && !accept;
		ev_clr = (reg_wr_in && reg_addr_in == `IFSF_REG_STAT)
			? reg_wdata_in[`IFSF_EV_W-1:0] : '0;
	end

	ifsf_sticky #(.W(`IFSF_EV_W)) u_events (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.set_in(ev_set),
		.clr_in(ev_clr),
		.flag_out(irq_stat)
	);

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(irq_stat & irq_mask);
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	start_time_held_a: // R1
	assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		!$past(accept && fresh) |-> $stable(start_time))
		else $error("start time moved without stream restart");

	count_zero_cause_a: // R3
	assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(sample_count < $past(sample_count)) |-> $past(restart))
		else $error("sample count fell without restart");

	count_step_a: // R4
	assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		$past(take) && !$past(restart)
		|-> sample_count == $past(sample_count) + 64'h1)
		else $error("sample count missed a sent sample");

	kfac_none_a: // R6
	assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		accept && !ctrl[`IFSF_CTRL_KVALID]
		|=> snap.antenna_field_correction == `IFSF_KFAC_NONE)
		else $error("undefined antenna correction not marked");

	snap_frozen_a: // R8
	assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		state != ifsf_pkg::ST_IDLE && $past(state != ifsf_pkg::ST_IDLE)
		|-> $stable(snap.block_count) && $stable(snap.fmt))
		else $error("header settings changed inside a frame");

	last_block_a: // R9
	assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		emit && next_last && state != ifsf_pkg::ST_HDR
		|-> blk_idx == snap.block_count - 16'h0001)
		else $error("frame ended on wrong block");

	status_follows_a: // R10
	assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		emit && state == ifsf_pkg::ST_HDR && hdr_idx == `IFSF_HDR_LAST
		&& snap.block_count != 16'h0000 |=> state == ifsf_pkg::ST_STAT)
		else $error("block did not open with status word");

	status_layout_a: // R12
	assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		stat_emit |=> word_data_out[15:8] == `IFSF_RSVD_ZERO
		&& word_data_out[31:16] == $past(agc_gain_in))
		else $error("status word layout wrong");

	invalid_flag_a: // R14
	assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		stat_emit && overload_in |=> word_data_out[0])
		else $error("overload not flagged in status word");

	body_length_a: // R15
	assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		state == ifsf_pkg::ST_BODY |-> word_cnt < snap.block_length_words)
		else $error("block body ran past its length");
endmodule // ifsf_framer

// File: dv/ifsf_consumer.sv
// stream consumer model that collects the words of one frame
`timescale 1ns/100ps
module ifsf_consumer (
	input wire logic core_clk_in, // block clock
	input wire logic rst_n_in, // sync reset, active low
	input wire logic slow_in, // stall every other cycle
	input wire logic clr_in, // forget captured frame
	input wire logic word_valid_in, // frame word valid
	input wire logic [31:0] word_data_in, // frame word
	input wire logic word_last_in, // last word of frame
	output logic word_ready_out // word taken
);
	logic [31:0] got[$];
	logic seen_last = 1'b0;
	int last_idx = -1;

	// stalls only when the bench asks, to stretch the handshake
	always @(posedge core_clk_in) begin
		if (!rst_n_in)
			word_ready_out <= 1'b0;
		else
			word_ready_out <= slow_in ? ~word_ready_out : 1'b1;
	end

	always @(posedge core_clk_in) begin
		if (!rst_n_in || clr_in) begin
			got.delete();
			seen_last <= 1'b0;
			last_idx <= -1;
		end else if (word_valid_in && word_ready_out) begin
			got.push_back(word_data_in);
			if (word_last_in) begin
				seen_last <= 1'b1;
				last_idx <= got.size() - 1;
			end
		end
	end
endmodule // ifsf_consumer

// File: dv/if_stream_block_framer_tb_top.sv
// register and frame stream bench of the IF stream block framer
`timescale 1ns/100ps
`include "ifsf_map.svh"
module if_stream_block_framer_tb_top;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, frame_req_in = 1'b0;
	logic [63:0] time_ns_in = 64'h0000_00AB_0000_1000;
	logic tuner_sync_in = 1'b0, blank_in = 1'b0, overload_in = 1'b0;
	logic [15:0] agc_gain_in = 16'h2220;
	logic sample_valid_in = 1'b1, slow = 1'b0, clr = 1'b0;
	ifsf_pkg::ifsf_sample_t sample_in;
	logic [31:0] reg_rdata_out, word_data_out, v;
	logic sample_ready_out, word_valid_out, word_last_out, word_ready_in;
	logic [4:0] hdr_len_out;
	logic busy_out, irq_out;
	logic [63:0] cnt = 64'h0, t0;
	// flags whose level outlived the last status word spill into the next
	logic [1:0] pend = 2'b00;
	int error_cnt = 0, n_checks = 0, sidx = 0, base = 0;

	always #10 core_clk_in = ~core_clk_in;

	ifsf_framer u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .frame_req_in(frame_req_in),
		.time_ns_in(time_ns_in), .tuner_sync_in(tuner_sync_in),
		.agc_gain_in(agc_gain_in), .blank_in(blank_in),
		.overload_in(overload_in), .sample_valid_in(sample_valid_in),
		.sample_in(sample_in), .sample_ready_out(sample_ready_out),
		.word_valid_out(word_valid_out), .word_data_out(word_data_out),
		.word_last_out(word_last_out), .word_ready_in(word_ready_in),
		.hdr_len_out(hdr_len_out), .busy_out(busy_out), .irq_out(irq_out));

	ifsf_consumer u_cons (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.slow_in(slow), .clr_in(clr), .word_valid_in(word_valid_out),
		.word_data_in(word_data_out), .word_last_in(word_last_out),
		.word_ready_out(word_ready_in));

	// ----------------------------------------------------------------
	// sample source and helpers
	// ----------------------------------------------------------------
	function automatic ifsf_pkg::ifsf_sample_t samp(input int k);
		samp.re = {16'h1000 + k[15:0], 16'h0A00 + k[15:0]};
		samp.im = {16'h2000 + k[15:0], 16'h0B00 + k[15:0]};
	endfunction

	initial sample_in = samp(0);
	always @(posedge core_clk_in)
		if (sample_valid_in && sample_ready_out) begin
			sidx <= sidx + 1;
			sample_in <= samp(sidx + 1);
		end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		#1 d = reg_rdata_out;
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// one frame, checked word by word against what the settings imply
	task automatic frame(input int nb, len, input logic [1:0] fmt,
			input logic kv, input logic [31:0] kf, input logic [5:0] uf,
			input logic bl, ov, mid);
		int spb, j, b, i;
		logic [31:0] e[$];
		ifsf_pkg::ifsf_sample_t s, s1;
		spb = (fmt < 2'h2) ? len / 2 : (fmt == 2'h2) ? len : len * 2;
		wr(`IFSF_REG_BLKCNT, 32'(nb));
		wr(`IFSF_REG_BLKLEN, 32'(len));
		wr(`IFSF_REG_KFAC, kf);
		wr(`IFSF_REG_CTRL, {22'h0, uf, fmt, kv, 1'b1});
		e = {t0[31:0], t0[63:32], cnt[31:0], cnt[63:32]};
		e.push_back(kv ? kf : `IFSF_KFAC_NONE);
		for (b = 0; b < nb; b++) begin
			e.push_back({agc_gain_in, `IFSF_RSVD_ZERO, uf,
				{bl, ov} | (b == 0 ? pend : 2'b00)});
			for (j = 0; j < len; j++) begin
				s = samp(base + (fmt < 2'h2 ? j / 2 : fmt == 2'h2 ? j : 2 * j));
				s1 = samp(base + 2 * j + 1);
				if (fmt < 2'h2)
					e.push_back(j % 2 ? s.im : s.re);
				else if (fmt == 2'h2)
					e.push_back({s.im[31:16], s.re[31:16]});
				else
					e.push_back({s1.re[31:16], s.re[31:16]});
			end
			base += spb;
		end
		cnt += 64'(nb * spb);
		pend = (nb > 0 ? 2'b00 : pend) | {bl, ov};
		@(posedge core_clk_in);
		blank_in <= bl;
		overload_in <= ov;
		frame_req_in <= 1'b1;
		clr <= 1'b1;
		@(posedge core_clk_in);
		frame_req_in <= 1'b0;
		clr <= 1'b0;
		// the clear of the old frame's last flag lands only now
		@(posedge core_clk_in);
		#1 chk(busy_out, 1'b1);
		if (mid) begin
			wr(`IFSF_REG_BLKLEN, 32'(len + 2));
			wr(`IFSF_REG_KFAC, ~kf);
		end
		for (i = 0; i < 4000 && !u_cons.seen_last; i++)
			@(posedge core_clk_in);
		#1 chk(u_cons.got.size(), e.size());
		chk(u_cons.last_idx, e.size() - 1);
		chk(busy_out, 1'b0);
		chk(sample_ready_out, 1'b0);
		for (i = 0; i < e.size() && i < u_cons.got.size(); i++)
			chk(u_cons.got[i], e[i]);
		$display("frame test done, %0d words", e.size());
	endtask

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		#1 chk(hdr_len_out, `IFSF_HDR_LEN);
		rd(`IFSF_REG_CTRL, v);
		chk(v, 32'h0);
		rd(8'h3C, v);
		chk(v, 32'h0);
		$display("reset test done");
		t0 = time_ns_in;
		frame(2, 2, `IFSF_FMT_C64_FIX, 1'b1, 32'hFFFF_FF9C, 6'h00, 0, 0, 0);
		rd(`IFSF_REG_STAT, v);
		chk(v[`IFSF_EV_DONE], 1'b1);
		chk(irq_out, 1'b0);
		wr(`IFSF_REG_MASK, 32'h1);
		repeat (2) @(posedge core_clk_in);
		#1 chk(irq_out, 1'b1);
		wr(`IFSF_REG_STAT, 32'h1);
		repeat (2) @(posedge core_clk_in);
		#1 chk(irq_out, 1'b0);
		$display("interrupt test done");
		// start time must stay put while the clock input moves on
		time_ns_in <= time_ns_in + 64'h100;
		frame(1, 2, `IFSF_FMT_C32_FIX, 1'b0, 32'h15, 6'h00, 0, 0, 1);
		slow <= 1'b1;
		frame(1, 1, `IFSF_FMT_R16_FIX, 1'b1, 32'h7, 6'h2A, 1, 1, 0);
		slow <= 1'b0;
		frame(0, 4, `IFSF_FMT_C64_FLT, 1'b1, 32'h8, 6'h00, 0, 0, 0);
		rd(`IFSF_REG_CNT_LO, v);
		chk(v, cnt[31:0]);
		for (int r = 0; r < 2; r++) begin
			if (r == 0)
				wr(`IFSF_REG_CMD, 32'h1);
			else begin
				@(posedge core_clk_in) tuner_sync_in <= 1'b1;
				@(posedge core_clk_in) tuner_sync_in <= 1'b0;
			end
			rd(`IFSF_REG_CNT_LO, v);
			chk(v, 32'h0);
			cnt = 64'h0;
			t0 = time_ns_in + 64'h5000;
			time_ns_in <= t0;
			frame(1, 2, `IFSF_FMT_C64_FLT, 1'b1, 32'h1, 6'h00, 0, 0, 0);
		end
		$display("restart test done");
		close_out();
	end

	initial begin
		#400000;
		error_cnt++;
		$display("unexpected at %0t: watchdog expired", $time);
		close_out();
	end
endmodule // if_stream_block_framer_tb_top
